//--- hdl/smc_blink.sv
// Status LED blink pattern generator.
`timescale 1ns/1ns
module smc_blink import smc_pkg::*; #(
  parameter int STEP_CYC = BLINK_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [PAT_STEPS-1:0] pattern,
  output logic led_a,
  output logic led_b
);
  logic [31:0] cnt_reg;
  logic [3:0] step_reg;
  wire step_end = (cnt_reg == 32'(STEP_CYC - 1));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h0;
      step_reg <= 4'h0;
    end else begin
      cnt_reg <= step_end ? 32'h0 : cnt_reg + 32'h1;
      if (step_end) begin
        step_reg <= step_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      led_a <= 1'b0;
      led_b <= 1'b0;
    end else begin
      led_a <= pattern[step_reg];
      led_b <= pattern[step_reg];
    end
  end
endmodule : smc_blink

//--- hdl/smc_cmd_if.sv
// Interface carrying a decoded command strobe and its arguments between modules.
`timescale 1ns/1ns
interface smc_cmd_if;
  import smc_pkg::*;
  logic valid;
  smc_cmd_e code;
  logic [DATA_W-1:0] arg0;
  logic [DATA_W-1:0] arg1;
  logic [DATA_W-1:0] arg2;
  modport src (output valid, output code, output arg0, output arg1, output arg2);
  modport dst (input valid, input code, input arg0, input arg1, input arg2);
endinterface : smc_cmd_if

//--- hdl/smc_core.sv
// Servo motion command interpreter and operating state logic.
`timescale 1ns/1ns
module smc_core import smc_pkg::*; #(
  parameter int STEP_CYC = BLINK_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic [DATA_W-1:0] actual_pos,
  output logic [DATA_W-1:0] demand_pos,
  output logic [DATA_W-1:0] limiter_start,
  output logic limiter_load,
  output logic [DATA_W-1:0] current_cmd,
  output logic [DATA_W-1:0] max_current,
  output logic [DATA_W-1:0] ff_gain,
  output logic [DATA_W-1:0] p_gain,
  output logic [DATA_W-1:0] i_gain,
  output logic [DATA_W-1:0] d_gain,
  output logic profile_start,
  output logic home_start,
  output logic frozen,
  output logic led_stat_a,
  output logic led_stat_b
);
  smc_cmd_if cmd ();

  smc_decode u_decode (
    .clock(clock),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .cmd(cmd)
  );

  logic [DATA_W-1:0] act_s1_reg;
  logic [DATA_W-1:0] act_s2_reg;
  logic [DATA_W-1:0] act_s3_reg;
  logic [DATA_W-1:0] act_pos_reg;
  logic [2:0] req_reg;
  logic master_mode_reg;
  logic cam_on_reg;
  logic cam_pos_reg;
  logic reject_reg;
  logic [DATA_W-1:0] recipe_reg;
  logic [DATA_W-1:0] rdata_next;
  smc_state_e state_reg;
  smc_state_e state_next;
  logic [PAT_STEPS-1:0] pattern;

  // The measured position comes from another domain, so it is resynchronised.
  // A whole word can tear while it changes, so a value is only taken once two
  // successive synchronised samples agree; this costs two cycles of latency.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      act_s1_reg <= '0;
      act_s2_reg <= '0;
      act_s3_reg <= '0;
      act_pos_reg <= '0;
    end else begin
      act_s1_reg <= actual_pos;
      act_s2_reg <= act_s1_reg;
      act_s3_reg <= act_s2_reg;
      if (act_s2_reg == act_s3_reg) act_pos_reg <= act_s3_reg;
    end
  end

  wire req_init = req_reg[REQ_INIT_BIT];
  wire req_run = req_reg[REQ_RUN_BIT];
  wire req_stop = req_reg[REQ_STOP_BIT];
  wire req_none = (req_reg == 3'h0);
  wire running = (state_reg == SMC_ST_RUN);
  wire at_target = (demand_pos == act_pos_reg);
  wire go = cmd.valid && running;
  wire is_cmd_stop = go && (cmd.code == SMC_STOP);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SMC_ST_DISABLE: begin
        if (req_stop) state_next = SMC_ST_STOP;
        else if (req_init) state_next = SMC_ST_INIT;
      end
      SMC_ST_INIT: begin
        if (req_stop) state_next = SMC_ST_STOP;
        else if (req_run) state_next = SMC_ST_RUN;
        else if (req_none) state_next = SMC_ST_DISABLE;
      end
      SMC_ST_RUN: begin
        if (req_stop || is_cmd_stop) state_next = SMC_ST_STOP;
        else if (!req_run) state_next = SMC_ST_INIT;
      end
      SMC_ST_STOP: begin
        if (req_none) state_next = SMC_ST_DISABLE;
      end
      default: state_next = SMC_ST_STOP;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= SMC_ST_DISABLE;
      req_reg <= 3'h0;
      master_mode_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (wr && addr == OFS_REQ) req_reg <= wdata[2:0];
      if (wr && addr == OFS_MODE) master_mode_reg <= wdata[MODE_MASTER_BIT];
    end
  end

  // Motion and parameter updates; any code not listed only clears reject_reg here.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      demand_pos <= '0;
      limiter_start <= '0;
      limiter_load <= 1'b0;
      current_cmd <= '0;
      max_current <= MAXCUR_RST;
      ff_gain <= '0;
      p_gain <= '0;
      i_gain <= '0;
      d_gain <= '0;
      profile_start <= 1'b0;
      home_start <= 1'b0;
      frozen <= 1'b0;
      cam_on_reg <= 1'b0;
      cam_pos_reg <= 1'b0;
      recipe_reg <= '0;
      reject_reg <= 1'b0;
    end else begin
      limiter_load <= 1'b0;
      profile_start <= 1'b0;
      home_start <= 1'b0;
      if (state_reg == SMC_ST_STOP) cam_on_reg <= 1'b0;
      if (go) begin
        reject_reg <= 1'b0;
        unique case (cmd.code)
          SMC_NOP: ;
          SMC_ABS_POS: begin
            demand_pos <= cmd.arg0;
            limiter_start <= demand_pos;
            limiter_load <= 1'b1;
          end
          SMC_REL_POS: begin
            demand_pos <= demand_pos + cmd.arg0;
            limiter_start <= demand_pos;
            limiter_load <= 1'b1;
          end
          SMC_ABS_ACT: begin
            demand_pos <= cmd.arg0;
            limiter_start <= act_pos_reg;
            limiter_load <= 1'b1;
          end
          SMC_ALIGN: demand_pos <= act_pos_reg;
          SMC_ABS_CUR: current_cmd <= cmd.arg0;
          SMC_REL_CUR: current_cmd <= current_cmd + cmd.arg0;
          SMC_MAX_CUR: begin
            if (!cmd.arg0[DATA_W-1] && cmd.arg0 != '0) max_current <= cmd.arg0;
            else reject_reg <= 1'b1;
          end
          SMC_FF: ff_gain <= cmd.arg0;
          SMC_PID: begin
            p_gain <= cmd.arg0;
            i_gain <= cmd.arg1;
            d_gain <= cmd.arg2;
          end
          SMC_PROFILE: profile_start <= 1'b1;
          SMC_HOME: home_start <= 1'b1;
          SMC_FREEZE: frozen <= cmd.arg0[0];
          SMC_REDEF: begin
            if (at_target && !frozen) demand_pos <= cmd.arg0;
            else reject_reg <= 1'b1;
          end
          SMC_RECIPE: begin
            if (master_mode_reg) recipe_reg <= cmd.arg0;
            else reject_reg <= 1'b1;
          end
          SMC_CAM: begin
            if (master_mode_reg) begin
              cam_on_reg <= 1'b1;
              cam_pos_reg <= cmd.arg0[0];
            end else reject_reg <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // Current read back at OFS_CURRENT is clamped to the maximum; the current_cmd output itself is not clamped.
  wire cur_over = $signed(current_cmd) > $signed(max_current);

  always_comb begin
    unique case (state_reg)
      SMC_ST_DISABLE: pattern = PAT_DISABLE;
      SMC_ST_INIT: pattern = PAT_INIT;
      SMC_ST_RUN: pattern = PAT_RUN;
      SMC_ST_STOP: pattern = PAT_STOP;
      default: pattern = PAT_STOP;
    endcase
  end

  smc_blink #(.STEP_CYC(STEP_CYC)) u_blink (
    .clock(clock),
    .rst(rst),
    .pattern(pattern),
    .led_a(led_stat_a),
    .led_b(led_stat_b)
  );

  wire [DATA_W-1:0] status_word = {18'h0, reject_reg, profile_start, at_target, frozen,
    cam_on_reg, cam_pos_reg, 4'h0, state_reg};

  always_comb begin
    unique case (addr)
      OFS_REQ: rdata_next = {29'h0, req_reg};
      OFS_STATUS: rdata_next = status_word;
      OFS_TARGET: rdata_next = demand_pos;
      OFS_CURRENT: rdata_next = cur_over ? max_current : current_cmd;
      OFS_MAXCUR: rdata_next = max_current;
      OFS_ACTPOS: rdata_next = act_pos_reg;
      OFS_RECIPE: rdata_next = recipe_reg;
      OFS_MODE: rdata_next = {31'h0, master_mode_reg};
      default: rdata_next = '0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) rdata <= '0;
    else rdata <= rd ? rdata_next : '0;
  end

  cam_gate_a: assert property (@(posedge clock) disable iff (rst)
    (go && cmd.code == SMC_CAM && !master_mode_reg && !cam_on_reg) |=> !cam_on_reg)
    else $error("cam mode entered outside master mode");
  nop_hold_a: assert property (@(posedge clock) disable iff (rst)
    (go && cmd.code == SMC_NOP) |=> $stable(demand_pos) && $stable(current_cmd))
    else $error("no-operation changed state");
  stop_exit_a: assert property (@(posedge clock) disable iff (rst)
    (state_reg == SMC_ST_STOP && !req_none) |=> state_reg == SMC_ST_STOP)
    else $error("stop left while requests set");
  align_copy_a: assert property (@(posedge clock) disable iff (rst)
    (go && cmd.code == SMC_ALIGN) |=> demand_pos == $past(act_pos_reg))
    else $error("demand not aligned");
  redef_block_a: assert property (@(posedge clock) disable iff (rst)
    (go && cmd.code == SMC_REDEF && frozen) |=> $stable(demand_pos))
    else $error("redefine while frozen");
  maxcur_pos_a: assert property (@(posedge clock) disable iff (rst)
    (go && cmd.code == SMC_MAX_CUR && cmd.arg0[DATA_W-1]) |=> $stable(max_current))
    else $error("negative maximum current accepted");
  rel_pos_a: assert property (@(posedge clock) disable iff (rst)
    (go && cmd.code == SMC_REL_POS) |=> demand_pos == $past(demand_pos) + $past(cmd.arg0))
    else $error("relative move wrong");
  recipe_gate_a: assert property (@(posedge clock) disable iff (rst)
    (go && cmd.code == SMC_RECIPE && !master_mode_reg) |=> $stable(recipe_reg))
    else $error("recipe changed outside master mode");

  sequence cam_enter_s;
    go && cmd.code == SMC_CAM && master_mode_reg;
  endsequence

  cam_select_a: assert property (@(posedge clock) disable iff (rst)
    cam_enter_s |=> cam_on_reg && cam_pos_reg == $past(cmd.arg0[0]))
    else $error("cam variant not selected");
  abs_move_a: assert property (@(posedge clock) disable iff (rst)
    (go && cmd.code == SMC_ABS_POS) |=> demand_pos == $past(cmd.arg0) && limiter_load)
    else $error("absolute move not started");
  abs_cur_a: assert property (@(posedge clock) disable iff (rst)
    (go && cmd.code == SMC_ABS_CUR) |=> current_cmd == $past(cmd.arg0))
    else $error("absolute current not set");
  profile_go_a: assert property (@(posedge clock) disable iff (rst)
    (go && cmd.code == SMC_PROFILE) |=> profile_start)
    else $error("profile run not started");
  act_start_a: assert property (@(posedge clock) disable iff (rst)
    (go && cmd.code == SMC_ABS_ACT) |=> limiter_start == $past(act_pos_reg))
    else $error("limiter not started at measured position");
  idle_hold_a: assert property (@(posedge clock) disable iff (rst)
    (cmd.valid && !running) |=> $stable(demand_pos) && $stable(current_cmd))
    else $error("command acted outside run state");
endmodule : smc_core

//--- hdl/smc_decode.sv
// Register-port command latch: turns a write to the command register into a command strobe.
`timescale 1ns/1ns
module smc_decode import smc_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  smc_cmd_if.src cmd
);
  logic [DATA_W-1:0] arg0_reg;
  logic [DATA_W-1:0] arg1_reg;
  logic [DATA_W-1:0] arg2_reg;
  logic valid_reg;
  smc_cmd_e code_reg;
  wire cmd_wr = wr && (addr == OFS_CMD);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arg0_reg <= '0;
      arg1_reg <= '0;
      arg2_reg <= '0;
      valid_reg <= 1'b0;
      code_reg <= SMC_NOP;
    end else begin
      valid_reg <= cmd_wr;
      if (cmd_wr) begin
        code_reg <= smc_cmd_e'(wdata[7:0]);
      end
      if (wr && addr == OFS_ARG0) begin
        arg0_reg <= wdata;
      end
      if (wr && addr == OFS_ARG1) begin
        arg1_reg <= wdata;
      end
      if (wr && addr == OFS_ARG2) begin
        arg2_reg <= wdata;
      end
    end
  end

  assign cmd.valid = valid_reg;
  assign cmd.code = code_reg;
  assign cmd.arg0 = arg0_reg;
  assign cmd.arg1 = arg1_reg;
  assign cmd.arg2 = arg2_reg;
endmodule : smc_decode

//--- hdl/smc_pkg.sv
// Package with command codes, states, register offsets and timing constants for the servo command block.
package smc_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFS_CMD = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_ARG0 = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_ARG1 = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_ARG2 = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_REQ = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_TARGET = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_CURRENT = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_MAXCUR = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_ACTPOS = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_RECIPE = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_MODE = 6'h2C;
  localparam logic [DATA_W-1:0] MAXCUR_RST = 32'h0000_1000;
  localparam int REQ_INIT_BIT = 0;
  localparam int REQ_RUN_BIT = 1;
  localparam int REQ_STOP_BIT = 2;
  localparam int MODE_MASTER_BIT = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_CAMPOS_BIT = 8;
  localparam int STAT_CAMON_BIT = 9;
  localparam int STAT_FROZEN_BIT = 10;
  localparam int STAT_ATTGT_BIT = 11;
  localparam int STAT_PROFILE_BIT = 12;
  localparam int STAT_REJECT_BIT = 13;
  localparam real CLK_MHZ = 125.0;
  localparam real BLINK_SHORT_MS = 100.0;
  localparam int BLINK_CYC = int'(BLINK_SHORT_MS * CLK_MHZ * 1000.0);
  localparam int PAT_STEPS = 16;

  typedef enum logic [7:0] {
    SMC_NOP = 8'h00, SMC_ABS_POS = 8'h01, SMC_REL_POS = 8'h02, SMC_ABS_CUR = 8'h03,
    SMC_REL_CUR = 8'h04, SMC_MAX_CUR = 8'h05, SMC_FF = 8'h06, SMC_PID = 8'h07,
    SMC_CUR_OFS = 8'h08, SMC_PROF_PROP = 8'h09, SMC_PROFILE = 8'h0A, SMC_HOME = 8'h0B,
    SMC_REDEF = 8'h0C, SMC_FREEZE = 8'h0D, SMC_STOP = 8'h0E, SMC_RECIPE = 8'h0F,
    SMC_CAM = 8'h10, SMC_ABS_ACT = 8'h11, SMC_ALIGN = 8'h12
  } smc_cmd_e;

  typedef enum logic [3:0] {
    SMC_ST_DISABLE = 4'h1, SMC_ST_INIT = 4'h2, SMC_ST_RUN = 4'h4, SMC_ST_STOP = 4'h8
  } smc_state_e;

  // Blink patterns, one bit per step, LSB first.
  localparam logic [PAT_STEPS-1:0] PAT_DISABLE = 16'h0005;
  localparam logic [PAT_STEPS-1:0] PAT_INIT = 16'h00FF;
  localparam logic [PAT_STEPS-1:0] PAT_RUN = 16'hFFFF;
  localparam logic [PAT_STEPS-1:0] PAT_STOP = 16'h5555;
endpackage : smc_pkg

//--- sim/smc_core_tb.sv
// Self-checking testbench for the servo command interpreter.
`timescale 1ns/1ns
module smc_core_tb;
  import smc_pkg::*;
  localparam int STEP = 4;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, apos, dpos, lstart, cur, maxc, ff, pg, ig, dg;
  logic wr, rd, lload, prof, home, frz, la, lb;
  logic [31:0] seed = 32'd14780;
  logic [31:0] v, d, c, s, r0, n;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #4 clock = ~clock;

  smc_plc_model u_plc (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));

  smc_core #(.STEP_CYC(STEP)) u_dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .actual_pos(apos), .demand_pos(dpos),
    .limiter_start(lstart), .limiter_load(lload), .current_cmd(cur), .max_current(maxc),
    .ff_gain(ff), .p_gain(pg), .i_gain(ig), .d_gain(dg), .profile_start(prof),
    .home_start(home), .frozen(frz), .led_stat_a(la), .led_stat_b(lb));

  function automatic logic [31:0] nx();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nx

  // Lit cycles in any whole pattern period depend only on the pattern, not on its phase.
  function automatic logic [31:0] lit(input logic [PAT_STEPS-1:0] p);
    return $countones(p) * STEP;
  endfunction : lit

  // Rising edges per period tell the blink codes apart even when the lit time is equal.
  function automatic logic [31:0] rises(input logic [PAT_STEPS-1:0] p);
    logic [31:0] k;
    k = '0;
    for (int i = 0; i < PAT_STEPS; i++) begin
      if (p[i] && !p[(i + PAT_STEPS - 1) % PAT_STEPS]) k++;
    end
    return k;
  endfunction : rises

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk

  task automatic cmd(input smc_cmd_e k, input logic [31:0] a0, a1, a2);
    u_plc.put(OFS_ARG0, a0);
    u_plc.put(OFS_ARG1, a1);
    u_plc.put(OFS_ARG2, a2);
    u_plc.put(OFS_CMD, {24'h00_0000, k});
    // One more edge executes the command; its one-cycle pulses stand until the next edge.
    @(posedge clock);
    #1;
  endtask : cmd

  task automatic req(input logic [31:0] q);
    u_plc.put(OFS_REQ, q);
    repeat (2) @(posedge clock);
    u_plc.get(OFS_STATUS, s);
  endtask : req

  // Settles on the new pattern first, then counts one full period on both LEDs.
  task automatic leds(input logic [PAT_STEPS-1:0] p);
    logic pv;
    logic on;
    logic [31:0] e;
    repeat (2 * PAT_STEPS * STEP) @(posedge clock);
    #1;
    pv = la & lb;
    n = '0;
    e = '0;
    repeat (PAT_STEPS * STEP) begin
      @(posedge clock);
      #1;
      on = la & lb;
      n += {31'h0, on};
      if (on && !pv) e++;
      pv = on;
    end
    chk(n, lit(p));
    chk(e, rises(p));
  endtask : leds

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    apos = 32'h0000_0000;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    apos <= nx();
    chk(maxc, MAXCUR_RST);
    chk(dpos, 32'h0);
    u_plc.get(OFS_STATUS, s);
    chk(s[3:0], SMC_ST_DISABLE);
    leds(PAT_DISABLE);
    cmd(SMC_ABS_POS, nx(), 0, 0);
    chk(dpos, 32'h0);
    $display("test reset and disable done");
    req(32'h1);
    chk(s[3:0], SMC_ST_INIT);
    leds(PAT_INIT);
    req(32'h3);
    chk(s[3:0], SMC_ST_RUN);
    leds(PAT_RUN);
    $display("test state entry done");
    for (int i = 0; i < 4; i++) begin
      v = nx();
      d = nx();
      c = nx() & 32'h0000_07FF;
      cmd(SMC_ABS_POS, v, 0, 0);
      chk(dpos, v);
      chk(lload, 1'b1);
      cmd(SMC_REL_POS, d, 0, 0);
      chk(dpos, v + d);
      cmd(SMC_ABS_CUR, c, 0, 0);
      chk(cur, c);
      cmd(SMC_NOP, nx(), nx(), nx());
      chk(dpos, v + d);
      chk(cur, c);
      cmd(SMC_REL_CUR, 32'h0000_0100, 0, 0);
      chk(cur, c + 32'h0000_0100);
      v = nx();
      d = nx();
      c = nx();
      cmd(SMC_PID, v, d, c);
      chk(pg, v);
      chk(ig, d);
      chk(dg, c);
      cmd(SMC_FF, v ^ c, 0, 0);
      chk(ff, v ^ c);
      cmd(SMC_PROFILE, 0, 0, 0);
      chk(prof, 1'b1);
      chk(home, 1'b0);
      cmd(SMC_FREEZE, 1, 0, 0);
      chk(frz, 1'b1);
      cmd(SMC_FREEZE, 0, 0, 0);
      chk(frz, 1'b0);
    end
    $display("test random commands done");
    cmd(SMC_MAX_CUR, 32'h8000_0000, 0, 0);
    chk(maxc, MAXCUR_RST);
    cmd(SMC_MAX_CUR, 32'h0, 0, 0);
    chk(maxc, MAXCUR_RST);
    cmd(SMC_MAX_CUR, 32'h0000_0200, 0, 0);
    chk(maxc, 32'h0000_0200);
    cmd(SMC_ABS_CUR, 32'h0000_0300, 0, 0);
    chk(cur, 32'h0000_0300);
    u_plc.get(OFS_CURRENT, s);
    chk(s, 32'h0000_0200);
    $display("test current limit done");
    v = dpos;
    cmd(SMC_REDEF, nx(), 0, 0);
    u_plc.get(OFS_STATUS, s);
    chk(s[STAT_REJECT_BIT], 1'b1);
    chk(dpos, v);
    v = nx();
    cmd(SMC_ABS_ACT, v, 0, 0);
    chk(lstart, apos);
    chk(dpos, v);
    cmd(SMC_ALIGN, 0, 0, 0);
    chk(dpos, apos);
    cmd(SMC_FREEZE, 1, 0, 0);
    v = nx();
    cmd(SMC_REDEF, v, 0, 0);
    chk(dpos, apos);
    cmd(SMC_FREEZE, 0, 0, 0);
    cmd(SMC_REDEF, v, 0, 0);
    chk(dpos, v);
    $display("test position commands done");
    u_plc.get(OFS_RECIPE, r0);
    cmd(SMC_CAM, 1, 0, 0);
    u_plc.get(OFS_STATUS, s);
    chk(s[STAT_REJECT_BIT], 1'b1);
    chk(s[STAT_CAMON_BIT], 1'b0);
    cmd(SMC_RECIPE, ~r0, 0, 0);
    u_plc.get(OFS_RECIPE, s);
    chk(s, r0);
    u_plc.put(OFS_MODE, 32'h1);
    for (int m = 0; m < 2; m++) begin
      cmd(SMC_CAM, m, 0, 0);
      u_plc.get(OFS_STATUS, s);
      chk(s[STAT_CAMON_BIT], 1'b1);
      chk(s[STAT_CAMPOS_BIT], m[0]);
    end
    v = nx();
    cmd(SMC_RECIPE, v, 0, 0);
    u_plc.get(OFS_RECIPE, s);
    chk(s, v);
    $display("test cam mode done");
    req(32'h4);
    chk(s[3:0], SMC_ST_STOP);
    leds(PAT_STOP);
    v = dpos;
    cmd(SMC_ABS_POS, ~v, 0, 0);
    chk(dpos, v);
    req(32'h1);
    chk(s[3:0], SMC_ST_STOP);
    req(32'h0);
    chk(s[3:0], SMC_ST_DISABLE);
    $display("test emergency stop done");
    final_report();
  end
endmodule : smc_core_tb

//--- sim/smc_plc_model.sv
// Controlling-party model that issues register writes and reads to the command block.
`timescale 1ns/1ns
module smc_plc_model import smc_pkg::*; (
  input wire logic clock,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [DATA_W-1:0] rdata
);
  initial begin
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
  end

  // Each strobe is one cycle; arguments are always written before the command word.
  task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    wdata <= ~d;
  endtask : put

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic get(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : get
endmodule : smc_plc_model
